// ---- hdl/tmw_timer16.sv ----
// 16-bit timer core: prescaler, counter sequences, compare channels A and
// B, flags and APB register file.
// Assumes an APB master on pclk; clk_en low freezes every register.
//
// Behaviour
// - Action zero leaves latch unchanged on match
// - New action acts from next match only
// - Force strobe applies action now, non-PWM
// - Only waveform mode picks the counting sequence
// - PWM: polarity; non-PWM: set, clear, toggle
// - Normal mode counts up, wraps at max
// - Normal: overflow set as count becomes zero
// - Counting never clears the overflow flag
// - Overflow interrupt execution clears overflow flag
// - Counter writable anytime in normal mode
// - Clear-on-match clears at compare A or capture
// - Top unbuffered; missed top runs to max
// - Reaching top sets compare A or capture flag
// - Action one toggles latch in clear-on-match
// - Toggle period is two times N(1+top)
// - Clear-on-match overflow on max-to-zero passage
// - Modes 5,6,7,14,15 are single-slope fast PWM
// - Fast PWM sets/clears at match and bottom
// - Fast PWM top fixed or register, then clear
// - Fast PWM top sets overflow, loads buffers
// - Compare flag set one timer tick after match
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "tmw_map.svh"

module tmw_timer16 (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               clk_en,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               ovf_int_ack,
    output var tmw_pkg::tmw_flags_s flags,
    output logic                    compare_a_output_latch,
    output logic                    compare_b_output_latch
);
    import tmw_pkg::*;

    tmw_ctrl_s   ctrl_reg;
    tmw_flags_s  flags_reg;
    tmw_flags_s  flag_set;
    tmw_flags_s  flag_clr;
    tmw_seq_e    seq;
    logic [15:0] count_reg;
    logic [15:0] count_next;
    logic [15:0] top;
    logic [15:0] cmpa_reg;
    logic [15:0] cmpa_buf_reg;
    logic [15:0] cmpb_reg;
    logic [15:0] cmpb_buf_reg;
    logic [15:0] capt_reg;
    logic [9:0]  pre_cnt_reg;
    logic [9:0]  pre_last;
    logic        pre_run;
    logic        tick_reg;
    logic        tick;
    logic        is_pwm;
    logic        cap_top;
    logic        at_top;
    logic        block_reg;
    logic        match_a;
    logic        match_b;
    logic        match_i;
    logic        pend_a_reg;
    logic        pend_b_reg;
    logic        pend_i_reg;
    logic        force_a_reg;
    logic        force_b_reg;
    logic        ovf_now;
    logic        acc;
    logic        wr;
    logic        wr_ctrl;
    logic        wr_force;
    logic        wr_count;
    logic        wr_cmpa;
    logic        wr_cmpb;
    logic        wr_capt;
    logic        wr_flags;
    logic        rd_hit;
    logic [31:0] rd_data;
    logic [31:0] prdata_reg;
    logic        pready_reg;
    logic        pslverr_reg;
    logic        latch_a;
    logic        latch_b;

    // APB: access phase answered one cycle after it starts; a write lands
    // only at the edge where the master samples pready high
    assign acc      = psel && penable && !pready_reg && clk_en;
    assign wr       = psel && penable && pready_reg && clk_en && pwrite
                      && rd_hit;
    assign wr_ctrl  = wr && paddr == `TMW_OFF_CTRL;
    assign wr_force = wr && paddr == `TMW_OFF_FORCE;
    assign wr_count = wr && paddr == `TMW_OFF_COUNT;
    assign wr_cmpa  = wr && paddr == `TMW_OFF_CMPA;
    assign wr_cmpb  = wr && paddr == `TMW_OFF_CMPB;
    assign wr_capt  = wr && paddr == `TMW_OFF_CAPT;
    assign wr_flags = wr && paddr == `TMW_OFF_FLAGS;

    always_comb begin
        rd_hit  = 1'b1;
        rd_data = 32'h0000_0000;
        if (paddr == `TMW_OFF_CTRL) begin
            rd_data = 32'(ctrl_reg);
        end else if (paddr == `TMW_OFF_FORCE) begin
            rd_data = 32'h0000_0000;
        end else if (paddr == `TMW_OFF_COUNT) begin
            rd_data = {16'h0000, count_reg};
        end else if (paddr == `TMW_OFF_CMPA) begin
            rd_data = {16'h0000, cmpa_buf_reg};
        end else if (paddr == `TMW_OFF_CMPB) begin
            rd_data = {16'h0000, cmpb_buf_reg};
        end else if (paddr == `TMW_OFF_CAPT) begin
            rd_data = {16'h0000, capt_reg};
        end else if (paddr == `TMW_OFF_FLAGS) begin
            rd_data = 32'(flags_reg);
        end else if (paddr == `TMW_OFF_STATUS) begin
            rd_data = {30'h0000_0000, latch_b, latch_a};
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
        end else if (clk_en) begin
            pready_reg  <= acc;
            pslverr_reg <= acc && !rd_hit;
            prdata_reg  <= (acc && !pwrite) ? rd_data : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `TMW_CTRL_RST;
            capt_reg <= `TMW_WORD_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= tmw_ctrl_s'(pwdata[`TMW_CTRL_W-1:0]);
            end
            if (wr_capt) begin
                capt_reg <= pwdata[15:0];
            end
        end
    end

    // Force strobes live one cycle and never touch flags or counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            force_a_reg <= 1'b0;
            force_b_reg <= 1'b0;
        end else if (clk_en) begin
            force_a_reg <= wr_force && pwdata[0] && !is_pwm;
            force_b_reg <= wr_force && pwdata[1] && !is_pwm;
        end
    end

    // Prescaler producing the timer clock enable
    always_comb begin
        pre_run  = 1'b1;
        pre_last = `TMW_LAST_DIV1;
        case (ctrl_reg.clk_sel)
            `TMW_CS_DIV1:    pre_last = `TMW_LAST_DIV1;
            `TMW_CS_DIV8:    pre_last = `TMW_LAST_DIV8;
            `TMW_CS_DIV64:   pre_last = `TMW_LAST_DIV64;
            `TMW_CS_DIV256:  pre_last = `TMW_LAST_DIV256;
            `TMW_CS_DIV1024: pre_last = `TMW_LAST_DIV1K;
            default:         pre_run  = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_cnt_reg <= 10'h000;
            tick_reg    <= 1'b0;
        end else if (clk_en) begin
            if (!pre_run || pre_cnt_reg >= pre_last) begin
                pre_cnt_reg <= 10'h000;
            end else begin
                pre_cnt_reg <= pre_cnt_reg + 10'h001;
            end
            tick_reg <= pre_run && pre_cnt_reg >= pre_last;
        end
    end

    assign tick = tick_reg && clk_en;

    // Sequence decode: mode field alone, actions never enter here
    always_comb begin
        seq     = SEQ_NORMAL;
        top     = `TMW_MAX;
        cap_top = 1'b0;
        case (ctrl_reg.mode)
            `TMW_WGM_CTC_A: begin
                seq = SEQ_CTC;
                top = cmpa_reg;
            end
            `TMW_WGM_CTC_I: begin
                seq     = SEQ_CTC;
                top     = capt_reg;
                cap_top = 1'b1;
            end
            `TMW_WGM_FAST8: begin
                seq = SEQ_FAST;
                top = `TMW_TOP8;
            end
            `TMW_WGM_FAST9: begin
                seq = SEQ_FAST;
                top = `TMW_TOP9;
            end
            `TMW_WGM_FAST10: begin
                seq = SEQ_FAST;
                top = `TMW_TOP10;
            end
            `TMW_WGM_FAST_I: begin
                seq     = SEQ_FAST;
                top     = capt_reg;
                cap_top = 1'b1;
            end
            `TMW_WGM_FAST_A: begin
                seq = SEQ_FAST;
                top = cmpa_reg;
            end
            // Phase correct codes are not built: they count as normal
            default: seq = SEQ_NORMAL;
        endcase
    end

    assign is_pwm = seq == SEQ_FAST;
    // Equality only: a top written below the count is passed by
    assign at_top = seq != SEQ_NORMAL && count_reg == top;
    assign count_next = at_top ? `TMW_BOTTOM : count_reg + 16'h0001;
    assign ovf_now = is_pwm ? at_top : count_reg == `TMW_MAX;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= `TMW_WORD_RST;
        end else if (wr_count) begin
            count_reg <= pwdata[15:0];
        end else if (tick) begin
            count_reg <= count_next;
        end
    end

    // A counter write masks matches at the next timer tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            block_reg <= 1'b0;
        end else if (wr_count) begin
            block_reg <= 1'b1;
        end else if (tick) begin
            block_reg <= 1'b0;
        end
    end

    // Compare registers: buffered in PWM, direct otherwise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmpa_buf_reg <= `TMW_WORD_RST;
            cmpa_reg     <= `TMW_WORD_RST;
            cmpb_buf_reg <= `TMW_WORD_RST;
            cmpb_reg     <= `TMW_WORD_RST;
        end else begin
            if (wr_cmpa) begin
                cmpa_buf_reg <= pwdata[15:0];
            end
            if (wr_cmpb) begin
                cmpb_buf_reg <= pwdata[15:0];
            end
            if (wr_cmpa && !is_pwm) begin
                cmpa_reg <= pwdata[15:0];
            end else if (tick && is_pwm && at_top) begin
                cmpa_reg <= cmpa_buf_reg;
            end
            if (wr_cmpb && !is_pwm) begin
                cmpb_reg <= pwdata[15:0];
            end else if (tick && is_pwm && at_top) begin
                cmpb_reg <= cmpb_buf_reg;
            end
        end
    end

    assign match_a = count_reg == cmpa_reg && !block_reg;
    assign match_b = count_reg == cmpb_reg && !block_reg;
    assign match_i = count_reg == capt_reg && cap_top && !block_reg;

    // Matches wait one timer tick before reaching the flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_a_reg <= 1'b0;
            pend_b_reg <= 1'b0;
            pend_i_reg <= 1'b0;
        end else if (tick) begin
            pend_a_reg <= match_a;
            pend_b_reg <= match_b;
            pend_i_reg <= match_i;
        end
    end

    always_comb begin
        flag_set      = `TMW_FLAGS_RST;
        flag_set.ovf  = tick && ovf_now;
        flag_set.cmpa = tick && pend_a_reg;
        flag_set.cmpb = tick && pend_b_reg;
        flag_set.capt = tick && pend_i_reg;
        flag_clr      = wr_flags ? tmw_flags_s'(pwdata[3:0]) : `TMW_FLAGS_RST;
        flag_clr.ovf  = flag_clr.ovf || (ovf_int_ack && clk_en);
    end

    // Set beats clear; counting itself never clears
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_reg <= `TMW_FLAGS_RST;
        end else begin
            flags_reg <= (flags_reg & ~flag_clr) | flag_set;
        end
    end

    tmw_wave_unit u_wave_a (
        .clk         (pclk),
        .rst_n       (presetn),
        .ce          (clk_en),
        .tick        (tick),
        .match       (match_a),
        .force_pulse (force_a_reg),
        .bottom      (at_top),
        .is_pwm      (is_pwm),
        .toggle_ok   (ctrl_reg.mode == `TMW_WGM_FAST_A),
        .action      (ctrl_reg.act_a),
        .latch       (latch_a)
    );

    tmw_wave_unit u_wave_b (
        .clk         (pclk),
        .rst_n       (presetn),
        .ce          (clk_en),
        .tick        (tick),
        .match       (match_b),
        .force_pulse (force_b_reg),
        .bottom      (at_top),
        .is_pwm      (is_pwm),
        .toggle_ok   (1'b0),
        .action      (ctrl_reg.act_b),
        .latch       (latch_b)
    );

    // Latches reach pins only through the port's own direction bit
    assign compare_a_output_latch = latch_a;
    assign compare_b_output_latch = latch_b;
    assign flags   = flags_reg;
    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_latch_hold_zero: assert property (
        (clk_en && ctrl_reg.act_a == `TMW_ACT_NONE) |=> $stable(latch_a))
        else $error("latch moved with action zero");
    a_force_sets_a: assert property (
        (force_a_reg && clk_en && ctrl_reg.act_a == `TMW_ACT_SET)
        |=> latch_a)
        else $error("force did not set latch");
    a_normal_incr: assert property (
        (tick && seq == SEQ_NORMAL && !wr_count)
        |=> count_reg == 16'($past(count_reg) + 16'h0001))
        else $error("normal mode did not increment");
    a_normal_ovf: assert property (
        (tick && seq == SEQ_NORMAL && count_reg == `TMW_MAX && !wr_count)
        |=> (count_reg == `TMW_BOTTOM && flags_reg.ovf))
        else $error("wrap without overflow flag");
    a_ovf_sticky: assert property (
        (flags_reg.ovf && !flag_clr.ovf) |=> flags_reg.ovf)
        else $error("overflow flag lost");
    a_ovf_ack: assert property (
        (ovf_int_ack && clk_en && !flag_set.ovf) |=> !flags_reg.ovf)
        else $error("ack did not clear overflow");
    a_ctc_clear: assert property (
        (tick && seq == SEQ_CTC && at_top && !wr_count)
        |=> count_reg == `TMW_BOTTOM)
        else $error("clear on match missed");
    a_ctc_ovf: assert property (
        (tick && seq == SEQ_CTC && count_reg == `TMW_MAX && !at_top)
        |=> flags_reg.ovf)
        else $error("ctc wrap without overflow");
    a_fast_reload: assert property (
        (tick && is_pwm && at_top)
        |=> (cmpa_reg == $past(cmpa_buf_reg) && flags_reg.ovf))
        else $error("buffer not loaded at top");
    // Prescaler gaps reach 1024 cycles, too long for a delay range
    logic        chk_match_a_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chk_match_a_reg <= 1'b0;
        end else if (tick) begin
            chk_match_a_reg <= match_a;
        end
    end

    a_match_delay: assert property (
        (tick && chk_match_a_reg) |=> flags_reg.cmpa)
        else $error("compare flag not set one tick later");
    a_count_frozen: assert property (
        (!tick && !wr_count) |=> $stable(count_reg))
        else $error("counter moved without tick");

endmodule
`default_nettype wire

// ---- hdl/tmw_map.svh ----
// Offsets, reset values, field codes and divider counts of the timer core.
// Assumes inclusion by bare name from the design files.
`ifndef TMW_MAP_SVH
`define TMW_MAP_SVH

// Register byte offsets, one aligned 32-bit word each
`define TMW_OFF_CTRL    8'h00
`define TMW_OFF_FORCE   8'h04
`define TMW_OFF_COUNT   8'h08
`define TMW_OFF_CMPA    8'h0C
`define TMW_OFF_CMPB    8'h10
`define TMW_OFF_CAPT    8'h14
`define TMW_OFF_FLAGS   8'h18
`define TMW_OFF_STATUS  8'h1C

// Control word width and reset values
`define TMW_CTRL_W      11
`define TMW_CTRL_RST    11'h000
`define TMW_WORD_RST    16'h0000
`define TMW_FLAGS_RST   4'h0

// Waveform mode codes
`define TMW_WGM_NORMAL  4'h0
`define TMW_WGM_CTC_A   4'h4
`define TMW_WGM_FAST8   4'h5
`define TMW_WGM_FAST9   4'h6
`define TMW_WGM_FAST10  4'h7
`define TMW_WGM_CTC_I   4'hC
`define TMW_WGM_FAST_I  4'hE
`define TMW_WGM_FAST_A  4'hF

// Fixed tops and counter extremes
`define TMW_TOP8        16'h00FF
`define TMW_TOP9        16'h01FF
`define TMW_TOP10       16'h03FF
`define TMW_MAX         16'hFFFF
`define TMW_BOTTOM      16'h0000

// Compare output action codes
`define TMW_ACT_NONE    2'h0
`define TMW_ACT_TOGGLE  2'h1
`define TMW_ACT_CLEAR   2'h2
`define TMW_ACT_SET     2'h3

// Timer clock select codes and last prescaler count for each divider
`define TMW_CS_DIV1     3'h1
`define TMW_CS_DIV8     3'h2
`define TMW_CS_DIV64    3'h3
`define TMW_CS_DIV256   3'h4
`define TMW_CS_DIV1024  3'h5
`define TMW_LAST_DIV1   10'h000
`define TMW_LAST_DIV8   10'h007
`define TMW_LAST_DIV64  10'h03F
`define TMW_LAST_DIV256 10'h0FF
`define TMW_LAST_DIV1K  10'h3FF

`endif

// ---- hdl/tmw_pkg.sv ----
// Types shared by the timer core and its testbench.
// Assumes the constants live in tmw_map.svh.
package tmw_pkg;

    typedef enum logic [1:0] {
        SEQ_NORMAL,
        SEQ_CTC,
        SEQ_FAST
    } tmw_seq_e;

    typedef struct packed {
        logic [2:0] clk_sel;
        logic [1:0] act_b;
        logic [1:0] act_a;
        logic [3:0] mode;
    } tmw_ctrl_s;

    typedef struct packed {
        logic capt;
        logic cmpb;
        logic cmpa;
        logic ovf;
    } tmw_flags_s;

endpackage

// ---- hdl/tmw_wave_unit.sv ----
// One compare output channel: drives its output latch from match, bottom
// and force events. Assumes all inputs come from logic on clk.
`timescale 1ns/100ps
`default_nettype none
`include "tmw_map.svh"

module tmw_wave_unit (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire logic       tick,
    input  wire logic       match,
    input  wire logic       force_pulse,
    input  wire logic       bottom,
    input  wire logic       is_pwm,
    input  wire logic       toggle_ok,
    input  wire logic [1:0] action,
    output logic            latch
);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            latch <= 1'b0;
        end else if (ce && action != `TMW_ACT_NONE) begin
            if (is_pwm) begin
                if (tick && bottom && action[1]) begin
                    // Bottom beats a match at top: compare at top is flat
                    latch <= ~action[0];
                end else if (tick && match) begin
                    if (action == `TMW_ACT_CLEAR) begin
                        latch <= 1'b0;
                    end else if (action == `TMW_ACT_SET) begin
                        latch <= 1'b1;
                    end else if (toggle_ok) begin
                        latch <= ~latch;
                    end
                end
            end else if ((tick && match) || force_pulse) begin
                case (action)
                    `TMW_ACT_TOGGLE: latch <= ~latch;
                    `TMW_ACT_CLEAR:  latch <= 1'b0;
                    default:         latch <= 1'b1;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ---- bench/tmw_pin_model.sv ----
// Port pin model beside compare output A.
// Assumes the latch and direction bit are levels on pclk.
`timescale 1ns/100ps
`default_nettype none

module tmw_pin_model (
    input  wire logic pclk,
    input  wire logic latch,
    input  wire logic pin_direction_bit,
    output logic      pin
);
    // Undriven pin floats to its pull-up, never to the last latch value
    always_ff @(posedge pclk) begin
        pin <= pin_direction_bit ? latch : 1'b1;
    end
endmodule

`default_nettype wire

// ---- bench/tb_tmw_timer16.sv ----
// Self-checking bench for the 16-bit timer core, one task per scenario.
// Assumes tmw_timer16, its map header and the pin model are compiled.
`timescale 1ns/100ps
`default_nettype none
`include "tmw_map.svh"

module tb_tmw_timer16;
    import tmw_pkg::*;
    logic        pclk, presetn, clk_en, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, err, ovf_int_ack, lat_a, lat_b;
    logic        pin_direction_bit, pin_a;
    tmw_flags_s  flags;
    int          num_errors, samples_checked, hi, lo;

    tmw_timer16 tmw_timer16_i (.pclk(pclk), .presetn(presetn),
        .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ovf_int_ack(ovf_int_ack), .flags(flags),
        .compare_a_output_latch(lat_a), .compare_b_output_latch(lat_b));
    tmw_pin_model tmw_pin_model_i (.pclk(pclk), .latch(lat_a),
        .pin_direction_bit(pin_direction_bit), .pin(pin_a));

    task automatic check(input string what, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // One APB transfer; an idle cycle follows so requests never collide
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        check("pready", 32'(pready), 32'h0000_0001);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    function automatic logic [31:0] ctl(input logic [3:0] m,
        input logic [1:0] a, b, input logic [2:0] cs);
        return {21'h0, cs, b, a, m};
    endfunction

    task automatic setup(input logic [31:0] cnt, cmpa, capt);
        apb(1'b1, `TMW_OFF_CTRL, 32'h0000_0000);
        apb(1'b1, `TMW_OFF_COUNT, cnt);
        apb(1'b1, `TMW_OFF_CMPA, cmpa);
        apb(1'b1, `TMW_OFF_CAPT, capt);
        apb(1'b1, `TMW_OFF_FLAGS, 32'h0000_000F);
    endtask

    // Latch high and low run lengths, counted in pclk cycles
    task automatic measure();
        int n;
        n = 0;
        while (lat_a !== 1'b0 && n < 3000) begin @(posedge pclk); n++; end
        while (lat_a !== 1'b1 && n < 3000) begin @(posedge pclk); n++; end
        hi = 0;
        while (lat_a === 1'b1 && hi < 3000) begin @(posedge pclk); hi++; end
        lo = 0;
        while (lat_a === 1'b0 && lo < 3000) begin @(posedge pclk); lo++; end
    endtask

    task automatic t_reset();
        apb(1'b0, `TMW_OFF_CTRL, 32'h0000_0000);
        check("ctrl", rd, 32'h0000_0000);
        apb(1'b0, `TMW_OFF_STATUS, 32'h0000_0000);
        check("status", rd, 32'h0000_0000);
        apb(1'b0, 8'h40, 32'h0000_0000);
        check("unmapped_err", 32'(err), 32'h0000_0001);
        check("unmapped_rd", rd, 32'h0000_0000);
        check("pin_released", 32'(pin_a), 32'h0000_0001);
    endtask

    task automatic t_force();
        logic [1:0] acts [4] = '{2'h3, 2'h2, 2'h1, 2'h0};
        logic       exp  [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, `TMW_OFF_CTRL, ctl(4'h0, acts[i], 2'h3, 3'h0));
            cyc(3);
            check("no_early", 32'(lat_a), i == 0 ? 0 : 32'(exp[i-1]));
            apb(1'b1, `TMW_OFF_FORCE, 32'h0000_0003);
            cyc(3);
            check("force_a", 32'(lat_a), 32'(exp[i]));
        end
        check("force_b", 32'(lat_b), 32'h0000_0001);
        pin_direction_bit <= 1'b1;
        cyc(2);
        check("pin_out", 32'(pin_a), 32'h0000_0001);
        apb(1'b1, `TMW_OFF_CTRL, ctl(4'h0, 2'h2, 2'h3, 3'h0));
        apb(1'b1, `TMW_OFF_FORCE, 32'h0000_0001);
        cyc(3);
        check("pin_low", 32'(pin_a), 32'h0000_0000);
    endtask

    task automatic t_normal();
        int n;
        n = 0;
        setup(32'h0000_FFFD, 32'h0000_0000, 32'h0000_0000);
        apb(1'b1, `TMW_OFF_CTRL, ctl(4'h0, 2'h0, 2'h0, 3'h1));
        while (flags.ovf !== 1'b1 && n < 100) begin @(posedge pclk); n++; end
        apb(1'b0, `TMW_OFF_COUNT, 32'h0000_0000);
        check("wrap", 32'(rd < 32'h0000_0010), 32'h0000_0001);
        cyc(20);
        check("ovf_held", 32'(flags.ovf), 32'h0000_0001);
        apb(1'b1, `TMW_OFF_COUNT, 32'h0000_8000);
        apb(1'b0, `TMW_OFF_COUNT, 32'h0000_0000);
        check("cnt_wr", 32'(rd - 32'h0000_8000 < 32'h10), 32'h1);
        ovf_int_ack <= 1'b1;
        @(posedge pclk);
        ovf_int_ack <= 1'b0;
        cyc(2);
        check("ovf_ack", 32'(flags.ovf), 32'h0000_0000);
    endtask

    task automatic t_wave();
        logic [3:0]  md [8] = '{4'h4, 4'hC, 4'h4, 4'h5, 4'h5, 4'h6, 4'hE, 4'hF};
        logic [1:0]  ac [8] = '{2'h1, 2'h1, 2'h1, 2'h2, 2'h3, 2'h2, 2'h2, 2'h1};
        logic [2:0]  cs [8] = '{3'h1, 3'h1, 3'h2, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1};
        logic [15:0] ca [8] = '{3, 2, 3, 16, 16, 16, 7, 7};
        int          eh [8] = '{4, 6, 32, 17, 239, 17, 8, 8};
        int          el [8] = '{4, 6, 32, 239, 17, 495, 24, 8};
        logic [3:0]  ef [8] = '{2, 10, 2, 3, 3, 3, 11, 3};
        for (int i = 0; i < 8; i++) begin
            setup(32'h0000_0000, 32'(ca[i]), 32'h0000_001F);
            if (md[i] == 4'hC) begin
                apb(1'b1, `TMW_OFF_CAPT, 32'h0000_0005);
            end
            apb(1'b1, `TMW_OFF_CTRL, ctl(md[i], ac[i], 2'h0, cs[i]));
            measure();
            check("high_len", 32'(hi), 32'(eh[i]));
            check("low_len", 32'(lo), 32'(el[i]));
            check("flags", 32'(flags & 4'hB), 32'(ef[i]));
        end
    endtask

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    initial begin
        repeat (40000) @(posedge pclk);
        num_errors++;
        end_of_test();
    end

    initial begin
        presetn = 1'b0;
        clk_en = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        ovf_int_ack = 1'b0;
        pin_direction_bit = 1'b0;
        num_errors = 0;
        samples_checked = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_force();
        t_normal();
        t_wave();
        end_of_test();
    end
endmodule

`default_nettype wire
